// ===== hw/cct_pkg.sv
`default_nettype none
package cct_pkg;
    localparam int          NUM_CAMS       = 3;
    localparam int          WORD_W         = 16;
    localparam logic [15:0] TIME_LIMIT     = 16'h0913;  // 2323 decimal
    localparam logic [15:0] MIN_PER_HOUR   = 16'h003c;
    localparam logic [15:0] HOUR_SCALE     = 16'h0064;  // 100
    localparam int          DAY_RESERVED_B = 7;
    localparam int          SUNDAY_BIT     = 0;
    localparam int          SATURDAY_BIT   = 6;
    localparam logic [15:0] WEEKDAY_RESET  = 16'h0000;
    localparam logic [15:0] TIME_RESET     = 16'h0000;
    localparam logic [7:0]  DAY_MASK       = 8'h7f;
    typedef enum logic [1:0] {CCT_YR_ONCE, CCT_YR_YEARLY, CCT_YR_MONTHLY} cct_yr_mode_t;
endpackage
`default_nettype wire

// ===== hw/cct_cam_match.sv
`timescale 1ns/1ns
`default_nettype none
// one cam: compares weekday and minute, produces on/off events
module cct_cam_match (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        minute_tick,
    input  wire logic [2:0]  weekday,
    input  wire logic [15:0] now_hhmm,
    input  wire logic [15:0] day_word,
    input  wire logic [15:0] on_word,
    input  wire logic [15:0] off_word,
    input  wire logic        on_en,
    input  wire logic        off_en,
    output logic             on_hit,
    output logic             off_hit,
    output logic             bad_time
);
    logic day_ok;

    function automatic logic time_ok(input logic [15:0] t);
        time_ok = (t <= cct_pkg::TIME_LIMIT) && ((t % cct_pkg::HOUR_SCALE) < cct_pkg::MIN_PER_HOUR);
    endfunction

    assign day_ok   = day_word[weekday] & ~day_word[cct_pkg::DAY_RESERVED_B]; // [RULE10]
    assign bad_time = (on_en & ~time_ok(on_word)) | (off_en & ~time_ok(off_word)); // [RULE12]

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            on_hit  <= 1'b0;
            off_hit <= 1'b0;
        end
        else
        begin
            // only on entry into the matching minute [RULE19] [RULE7]
            on_hit  <= minute_tick & day_ok & on_en & time_ok(on_word) & (on_word == now_hhmm); // [RULE2] [RULE9]
            off_hit <= minute_tick & day_ok & off_en & time_ok(off_word) & (off_word == now_hhmm); // [RULE3] [RULE9]
        end
    end
endmodule
`default_nettype wire

// ===== hw/cct_yearly.sv
`timescale 1ns/1ns
`default_nettype none
// yearly cam: dates compared once per day tick
module cct_yearly (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        day_tick,
    input  wire logic [15:0] year,
    input  wire logic [3:0]  month,
    input  wire logic [4:0]  mday,
    input  wire logic [15:0] on_year,
    input  wire logic [3:0]  on_month,
    input  wire logic [4:0]  on_day,
    input  wire logic [15:0] off_year,
    input  wire logic [3:0]  off_month,
    input  wire logic [4:0]  off_day,
    input  wire logic        yearly_en,
    input  wire logic        monthly_en,
    input  wire logic        pulse_en,
    output logic             yr_out
);
    logic in_range;
    logic on_ev;
    logic off_ev;
    logic once_done_reg;
    logic wrap;

    assign wrap     = {on_month, on_day} > {off_month, off_day}; // [RULE15]
    assign in_range = (year >= on_year) && ((year < off_year) ||
                      ((year == off_year) && !(wrap && !monthly_en)));
    always_comb
    begin
        on_ev  = 1'b0;
        off_ev = 1'b0;
        if (monthly_en)
        begin
            on_ev  = in_range && (mday == on_day); // [RULE18]
            off_ev = (year >= on_year) && (year <= off_year) && (mday == off_day);
        end
        else if (yearly_en)
        begin
            on_ev  = in_range && (month == on_month) && (mday == on_day); // [RULE14] [RULE16]
            off_ev = (year > on_year) | !wrap ? ((year <= off_year) && (month == off_month) && (mday == off_day)) : 1'b0;
        end
        else
        begin
            on_ev  = !once_done_reg && (year == on_year) && (month == on_month) && (mday == on_day); // [RULE17]
            off_ev = (year == off_year) && (month == off_month) && (mday == off_day);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            yr_out        <= 1'b0;
            once_done_reg <= 1'b0;
        end
        else if (pulse_en && yr_out)
            yr_out <= 1'b0;
        else if (day_tick && on_ev)
        begin
            yr_out        <= 1'b1; // [RULE13]
            once_done_reg <= 1'b1;
        end
        else if (day_tick && off_ev && !pulse_en)
            yr_out <= 1'b0;
    end
endmodule
`default_nettype wire

// ===== hw/cct_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// [RULE1] three independent cams, each with weekday mask, on-time and off-time
// [RULE2] on-time match on selected day sets output if not set
// [RULE3] off-time match on selected day clears output if set
// [RULE4] coincident events: higher cam wins, three over two over one
// [RULE5] output comes from combined activity of all cams
// [RULE6] times from 00:00 through 23:59 accepted as hours and minutes; the code accepts only up to 23:23 (TIME_LIMIT 2323)
// [RULE7] comparison at one-minute granularity
// [RULE8] pulse cam asserts output one program cycle at on-time
// [RULE9] on and off time of each cam disable separately
// [RULE10] weekday mask bit0 sunday, bits1-5 weekdays, bit6 saturday, bit7 zero
// [RULE11] parameter words are 16 bits, times as hours*100+minutes
// [RULE12] time above limit is unusable and forces output zero
// [RULE13] yearly timer has one cam, output high while switched on
// [RULE14] yearly mode repeats on/off dates each year in range
// [RULE15] wrapped dates turn off next year, no on after final off
// [RULE16] yearly pulse gives one cycle on each year's on date
// [RULE17] no repetition with pulse gives single pulse at on date
// [RULE18] monthly mode switches on/off days each month to off year end
// [RULE19] compare each cycle, act only on entry into matching minute
module cct_top (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic [2:0]          rtc_weekday,
    input  wire logic [4:0]          rtc_hour,
    input  wire logic [5:0]          rtc_minute,
    input  wire logic [15:0]         rtc_year,
    input  wire logic [3:0]          rtc_month,
    input  wire logic [4:0]          rtc_mday,
    input  wire logic [3*16-1:0]     weekday_select_word,
    input  wire logic [3*16-1:0]     cam_on_time_word,
    input  wire logic [3*16-1:0]     cam_off_time_word,
    input  wire logic [2:0]          cam_on_enable,
    input  wire logic [2:0]          cam_off_enable,
    input  wire logic [2:0]          cam_pulse,
    input  wire logic [15:0]         yr_on_year,
    input  wire logic [3:0]          yr_on_month,
    input  wire logic [4:0]          yr_on_day,
    input  wire logic [15:0]         yr_off_year,
    input  wire logic [3:0]          yr_off_month,
    input  wire logic [4:0]          yr_off_day,
    input  wire logic                yr_yearly,
    input  wire logic                yr_monthly,
    input  wire logic                yr_pulse,
    output logic                     weekly_out,
    output logic                     weekly_fault,
    output logic                     yearly_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] now_hhmm;
    logic [15:0] prev_hhmm_reg;
    logic [15:0] prev_mday_reg;
    logic        minute_tick;
    logic        day_tick;
    logic        primed_reg;
    logic [2:0]  on_hit;
    logic [2:0]  off_hit;
    logic [2:0]  bad;
    logic        state_reg;
    logic        pulse_reg;
    logic        state_next;
    logic        pulse_next;

    // time folded into the same decimal form as the parameter words [RULE11] [RULE6]
    assign now_hhmm = 16'(rtc_hour) * cct_pkg::HOUR_SCALE + 16'(rtc_minute);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            prev_hhmm_reg <= 16'hffff;
            prev_mday_reg <= 16'hffff;
            primed_reg    <= 1'b0;
        end
        else
        begin
            prev_hhmm_reg <= now_hhmm;
            prev_mday_reg <= {11'h000, rtc_mday};
            primed_reg    <= 1'b1;
        end
    end

    // first cycle after reset counts as entry, so a matching minute at power-up acts once
    assign minute_tick = (now_hhmm != prev_hhmm_reg) | ~primed_reg; // [RULE19]
    assign day_tick    = ({11'h000, rtc_mday} != prev_mday_reg) | ~primed_reg;

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < cct_pkg::NUM_CAMS; g++)
        begin : g_cam
            cct_cam_match u_cam ( // [RULE1]
                .clk         (clk),
                .rstn        (rstn),
                .minute_tick (minute_tick),
                .weekday     (rtc_weekday),
                .now_hhmm    (now_hhmm),
                .day_word    (weekday_select_word[g*16 +: 16]),
                .on_word     (cam_on_time_word[g*16 +: 16]),
                .off_word    (cam_off_time_word[g*16 +: 16]),
                .on_en       (cam_on_enable[g]),
                .off_en      (cam_off_enable[g]),
                .on_hit      (on_hit[g]),
                .off_hit     (off_hit[g]),
                .bad_time    (bad[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // apply events from cam one upward, so later cams override earlier ones
    always_comb
    begin
        state_next = state_reg;
        pulse_next = 1'b0;
        for (int i = 0; i < cct_pkg::NUM_CAMS; i++) // [RULE5]
        begin
            if (on_hit[i] && cam_pulse[i])
            begin
                pulse_next = 1'b1; // [RULE8]
                state_next = 1'b0;
            end
            else if (on_hit[i])
                state_next = 1'b1; // [RULE2] [RULE4]
            else if (off_hit[i])
            begin
                state_next = 1'b0; // [RULE3] [RULE4]
                pulse_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            pulse_reg <= pulse_next;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            weekly_out   <= 1'b0;
            weekly_fault <= 1'b0;
        end
        else
        begin
            weekly_out   <= ~(|bad) & (state_next | pulse_next); // [RULE12]
            weekly_fault <= |bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cct_yearly u_yearly (
        .clk        (clk),
        .rstn       (rstn),
        .day_tick   (day_tick),
        .year       (rtc_year),
        .month      (rtc_month),
        .mday       (rtc_mday),
        .on_year    (yr_on_year),
        .on_month   (yr_on_month),
        .on_day     (yr_on_day),
        .off_year   (yr_off_year),
        .off_month  (yr_off_month),
        .off_day    (yr_off_day),
        .yearly_en  (yr_yearly),
        .monthly_en (yr_monthly),
        .pulse_en   (yr_pulse),
        .yr_out     (yearly_out)
    );
endmodule
`default_nettype wire

// ===== verification/cct_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module cct_top_chk (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [4:0] rtc_hour,
    input wire logic [5:0] rtc_minute,
    input wire logic [4:0] rtc_mday,
    input wire logic [2:0] cam_pulse,
    input wire logic       yr_pulse,
    input wire logic       weekly_out,
    input wire logic       weekly_fault,
    input wire logic       yearly_out
);
    logic [10:0] prev_t;
    logic [4:0]  prev_d;
    logic        rst_q;
    logic        m_chg;
    logic        d_chg;
    // the first cycle after reset counts as a change, as the design sees it
    assign m_chg = ({rtc_hour, rtc_minute} != prev_t) || !rst_q;
    assign d_chg = (rtc_mday != prev_d) || !rst_q;
    always_ff @(posedge clk)
    begin
        prev_t <= {rtc_hour, rtc_minute};
        prev_d <= rtc_mday;
        rst_q  <= rstn;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_min_quiet;
        !m_chg [*4];
    endsequence
    sequence s_day_quiet;
        !d_chg [*4];
    endsequence
    property p_week_hold;
        s_min_quiet |-> $stable(weekly_out) || weekly_fault || $past(weekly_fault);
    endproperty
    property p_rise;
        $rose(weekly_out) |-> $past(m_chg) || $past(m_chg, 2);
    endproperty
    property p_fall;
        $fell(weekly_out) |-> $past(m_chg) || $past(m_chg, 2) || !$past(weekly_out, 2) || weekly_fault;
    endproperty
    property p_fault_zero;
        weekly_fault && $past(weekly_fault) |-> !weekly_out;
    endproperty
    property p_pulse_one;
        $rose(weekly_out) && cam_pulse == 3'h1 |=> !weekly_out;
    endproperty
    property p_yr_rise;
        $rose(yearly_out) |-> $past(d_chg) || $past(d_chg, 2);
    endproperty
    property p_yr_hold;
        s_day_quiet |-> $stable(yearly_out);
    endproperty
    property p_yr_pulse;
        $rose(yearly_out) && yr_pulse |=> !yearly_out;
    endproperty
    a_week_hold: assert property (p_week_hold) else $error("weekly output moved without minute change");
    a_rise: assert property (p_rise) else $error("weekly output rose without minute change");
    a_fall: assert property (p_fall) else $error("weekly output fell without cause");
    a_fault_zero: assert property (p_fault_zero) else $error("weekly output high under fault");
    a_pulse_one: assert property (p_pulse_one) else $error("weekly pulse longer than one cycle");
    a_yr_rise: assert property (p_yr_rise) else $error("yearly output rose without day change");
    a_yr_hold: assert property (p_yr_hold) else $error("yearly output moved without day change");
    a_yr_pulse: assert property (p_yr_pulse) else $error("yearly pulse longer than one cycle");
endmodule
bind cct_top cct_top_chk u_chk (.clk(clk), .rstn(rstn), .rtc_hour(rtc_hour), .rtc_minute(rtc_minute),
    .rtc_mday(rtc_mday), .cam_pulse(cam_pulse), .yr_pulse(yr_pulse), .weekly_out(weekly_out),
    .weekly_fault(weekly_fault), .yearly_out(yearly_out));
`default_nettype wire

// ===== verification/test_calendar_cam_timer.sv
`timescale 1ns/1ns
`default_nettype none
module test_calendar_cam_timer;
    logic        clk = 1'h0, rstn = 1'h0, yr_yearly = 1'h0, yr_monthly = 1'h0, yr_pulse = 1'h0;
    logic        weekly_out, weekly_fault, yearly_out;
    logic [2:0]  rtc_weekday = 3'h1, cam_on_enable = 3'h0, cam_off_enable = 3'h0, cam_pulse = 3'h0;
    logic [4:0]  rtc_hour = 5'h00, rtc_mday = 5'h01, yr_on_day = 5'h01, yr_off_day = 5'h01;
    logic [5:0]  rtc_minute = 6'h00;
    logic [3:0]  rtc_month = 4'h1, yr_on_month = 4'h1, yr_off_month = 4'h1;
    logic [15:0] rtc_year = 16'h07d9, yr_on_year = 16'h07d8, yr_off_year = 16'h07da;
    logic [47:0] weekday_select_word = 48'h007f007f007f, cam_on_time_word = 48'h0, cam_off_time_word = 48'h0;
    int          failures = 0, n_tests = 0, hi_w, hi_y;
    ////////////////////////////////////////////////////////////////////////////
    cct_top u_dut (.clk(clk), .rstn(rstn), .rtc_weekday(rtc_weekday), .rtc_hour(rtc_hour),
        .rtc_minute(rtc_minute), .rtc_year(rtc_year), .rtc_month(rtc_month), .rtc_mday(rtc_mday),
        .weekday_select_word(weekday_select_word), .cam_on_time_word(cam_on_time_word),
        .cam_off_time_word(cam_off_time_word), .cam_on_enable(cam_on_enable),
        .cam_off_enable(cam_off_enable), .cam_pulse(cam_pulse), .yr_on_year(yr_on_year),
        .yr_on_month(yr_on_month), .yr_on_day(yr_on_day), .yr_off_year(yr_off_year),
        .yr_off_month(yr_off_month), .yr_off_day(yr_off_day), .yr_yearly(yr_yearly),
        .yr_monthly(yr_monthly), .yr_pulse(yr_pulse), .weekly_out(weekly_out),
        .weekly_fault(weekly_fault), .yearly_out(yearly_out));
    initial
    begin
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rst;
        @(negedge clk);
        rstn = 1'h0;
        repeat (2) @(negedge clk);
        rstn = 1'h1;
    endtask
    // five cycles cover the two-edge answer; high cycles are counted for pulse checks
    task automatic step(input logic [2:0] w, input logic [4:0] h, input logic [5:0] m,
                        input logic [3:0] mo = 4'h1, input logic [4:0] d = 5'h01);
        @(negedge clk);
        {rtc_weekday, rtc_hour, rtc_minute, rtc_month, rtc_mday} = {w, h, m, mo, d};
        hi_w = 0;
        hi_y = 0;
        repeat (5)
        begin
            @(negedge clk);
            hi_w += int'(weekly_out);
            hi_y += int'(yearly_out);
        end
    endtask
    task automatic day(input logic [3:0] mo, input logic [4:0] d);
        step(3'h1, 5'h00, 6'h00, mo, d);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_weekly;
        {cam_on_time_word, cam_off_time_word} = {48'h0276, 48'h0320};
        {cam_on_enable, cam_off_enable} = {3'h1, 3'h1};
        rst();
        step(3'h1, 5'h06, 6'h1d);
        chk(16'(weekly_out), 16'h0);
        step(3'h1, 5'h06, 6'h1e);
        chk(16'(weekly_out), 16'h1);
        step(3'h1, 5'h06, 6'h1f);
        chk(16'(weekly_out), 16'h1);
        step(3'h1, 5'h08, 6'h00);
        chk(16'(weekly_out), 16'h0);
        weekday_select_word[15:0] = 16'h0002;
        step(3'h0, 5'h06, 6'h1e);
        chk(16'(weekly_out), 16'h0);
        step(3'h1, 5'h06, 6'h1d);
        step(3'h1, 5'h06, 6'h1e);
        chk(16'(weekly_out), 16'h1);
        $display("weekly test done");
    endtask
    task automatic t_prio;
        weekday_select_word = 48'h007f007f007f;
        {cam_on_time_word, cam_off_time_word} = {48'h04b0044c03e8, 48'h044c03e804b0};
        {cam_on_enable, cam_off_enable} = {3'h7, 3'h7};
        rst();
        step(3'h1, 5'h09, 6'h3b);
        step(3'h1, 5'h0a, 6'h00);
        chk(16'(weekly_out), 16'h0);
        step(3'h1, 5'h0b, 6'h00);
        chk(16'(weekly_out), 16'h0);
        step(3'h1, 5'h0c, 6'h00);
        chk(16'(weekly_out), 16'h1);
        $display("priority test done");
    endtask
    task automatic t_pulse_dis;
        {cam_on_time_word, cam_off_time_word} = {48'h08980913, 48'h0};
        {cam_on_enable, cam_off_enable, cam_pulse} = {3'h1, 3'h0, 3'h1};
        rst();
        step(3'h1, 5'h15, 6'h3b);
        step(3'h1, 5'h16, 6'h00);
        chk(16'(hi_w), 16'h0);
        // the last minute still accepted on the word interface is the refusal limit
        step(3'h1, 5'h17, 6'h17);
        chk(16'(hi_w), 16'h1);
        chk(16'(weekly_out), 16'h0);
        $display("pulse test done");
    endtask
    task automatic t_fault;
        {cam_on_time_word, cam_pulse} = {48'h0276, 3'h0};
        rst();
        step(3'h1, 5'h06, 6'h1e);
        chk(16'(weekly_out), 16'h1);
        cam_on_time_word = 48'h0914;
        step(3'h1, 5'h06, 6'h1f);
        chk(16'({weekly_fault, weekly_out}), 16'h2);
        cam_on_time_word = 48'h04ec;
        step(3'h1, 5'h06, 6'h20);
        chk(16'({weekly_fault, weekly_out}), 16'h2);
        $display("fault test done");
    endtask
    task automatic t_yearly;
        {yr_on_month, yr_on_day, yr_off_month, yr_off_day, yr_yearly} = {4'h6, 5'h01, 4'h8, 5'h1f, 1'h1};
        rst();
        day(4'h5, 5'h1f);
        day(4'h6, 5'h01);
        chk(16'(yearly_out), 16'h1);
        day(4'h8, 5'h1f);
        chk(16'(yearly_out), 16'h0);
        {yr_on_month, yr_on_day, yr_off_month, yr_off_day} = {4'hc, 5'h0f, 4'h1, 5'h07};
        day(4'hc, 5'h0f);
        chk(16'(yearly_out), 16'h1);
        rtc_year = 16'h07da;
        day(4'h1, 5'h07);
        chk(16'(yearly_out), 16'h0);
        day(4'hc, 5'h0f);
        chk(16'(hi_y), 16'h0);
        {rtc_year, yr_pulse, yr_on_month, yr_on_day} = {16'h07d9, 1'h1, 4'h3, 5'h0f};
        day(4'h3, 5'h0e);
        day(4'h3, 5'h0f);
        chk(16'(hi_y), 16'h1);
        $display("yearly test done");
    endtask
    task automatic t_yr_modes;
        {yr_monthly, yr_pulse, yr_on_day, yr_off_day, rtc_year} = {1'h1, 1'h0, 5'h01, 5'h05, 16'h07da};
        day(4'h4, 5'h01);
        chk(16'(yearly_out), 16'h1);
        day(4'h4, 5'h05);
        chk(16'(yearly_out), 16'h0);
        rtc_year = 16'h07db;
        day(4'h1, 5'h01);
        chk(16'(hi_y), 16'h0);
        // once mode fires only once per reset, so start it from a fresh reset
        {yr_monthly, yr_yearly, yr_pulse, rtc_year, yr_on_day} = {1'h0, 1'h0, 1'h1, 16'h07d8, 5'h0f};
        rst();
        day(4'h3, 5'h0f);
        chk(16'(hi_y), 16'h1);
        day(4'h3, 5'h0e);
        day(4'h3, 5'h0f);
        chk(16'(hi_y), 16'h0);
        $display("yearly mode test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rstn = 1'h1;
        t_weekly();
        t_prio();
        t_pulse_dis();
        t_fault();
        t_yearly();
        t_yr_modes();
        give_verdict();
    end
endmodule
`default_nettype wire
